/* File: verilog/conv_check_pkg.sv */
// constants, link operations and integrity-byte functions
package conv_check_pkg;
  localparam logic [7:0] addr_link_cfg     = 8'h02;
  localparam logic [7:0] addr_main_ofs_lo  = 8'h07;
  localparam logic [7:0] addr_main_ofs_mid = 8'h08;
  localparam logic [7:0] addr_main_ofs_hi  = 8'h09;
  localparam logic [7:0] addr_main_fs_lo   = 8'h0a;
  localparam logic [7:0] addr_main_fs_mid  = 8'h0b;
  localparam logic [7:0] addr_main_fs_hi   = 8'h0c;
  localparam logic [7:0] addr_aux_ofs_lo   = 8'h17;
  localparam logic [7:0] addr_aux_ofs_hi   = 8'h18;
  localparam logic [7:0] addr_aux_fs_lo    = 8'h19;
  localparam logic [7:0] addr_aux_fs_hi    = 8'h1a;

  localparam int         check_mode_lsb    = 0;
  localparam logic [1:0] check_mode_reset  = 2'h1;
  localparam logic [1:0] check_sum_mode    = 2'h1;
  localparam logic [1:0] check_crc_mode    = 2'h2;
  localparam logic [7:0] check_offset      = 8'h9b;
  localparam logic [7:0] crc_poly_low      = 8'h07;

  localparam logic [23:0] main_ofs_reset   = 24'h000000;
  localparam logic [23:0] main_fs_unity    = 24'h400000;
  localparam logic [15:0] aux_ofs_reset    = 16'h0000;
  localparam logic [15:0] aux_fs_unity     = 16'h4000;
  localparam int          main_fs_shift    = 22;
  localparam int          aux_fs_shift     = 14;
  localparam int          main_bytes       = 4;
  localparam int          aux_bytes        = 3;
  localparam logic [4:0]  cal_samples      = 5'h10;
  localparam int          cal_avg_shift    = 4;

  typedef enum logic [2:0] {
    op_read_main, op_read_aux, op_reg_write, op_reg_read, op_cal_main_ofs, op_cal_aux_ofs
  } link_op_e;

  function automatic logic [7:0] check_sum(input logic [31:0] d, input int nb);
    logic [7:0] s;
    s = check_offset;
    for (int i = 0; i < 4; i++) begin
      if (i < nb) s = s + d[8*i +: 8];
    end
    return s;
  endfunction

  // msb-first shift with zero start equals long division of data times x^8
  function automatic logic [7:0] crc8(input logic [31:0] d, input int nb);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 3; i >= 0; i--) begin
      if (i < nb) begin
        c = c ^ d[8*i +: 8];
        for (int b = 0; b < 8; b++) begin
          c = c[7] ? ({c[6:0], 1'b0} ^ crc_poly_low) : {c[6:0], 1'b0};
        end
      end
    end
    return c;
  endfunction
endpackage

/* File: verilog/conv_link_if.sv */
// byte link between the converter data path and its host controller
`timescale 1ns/1ps
interface conv_link_if;
  import conv_check_pkg::*;
  logic       req_valid;
  logic       req_ready;
  link_op_e   req_op;
  logic [7:0] req_addr;
  logic [7:0] req_data;
  logic       rsp_valid;
  logic [7:0] rsp_byte;
  logic       rsp_last;
  logic       serial_out_ready_pin;
  logic       aux_data_ready;

  modport device (input req_valid, req_op, req_addr, req_data,
                  output req_ready, rsp_valid, rsp_byte, rsp_last,
                  serial_out_ready_pin, aux_data_ready);
  modport host (output req_valid, req_op, req_addr, req_data,
                input req_ready, rsp_valid, rsp_byte, rsp_last,
                serial_out_ready_pin, aux_data_ready);
endinterface

/* File: verilog/conv_result_device.sv */
// converter end: result correction, correction registers, integrity byte
`timescale 1ns/1ps
// Contract
// - check over four main, three aux bytes
// - checksum mode: byte sum plus 9Bh
// - host verifies checksum, rereads on mismatch
// - crc mode: remainder by x^8+x^2+x+1
// - dividend is result with eight zeros appended
// - xor aligned polynomial until below 100h
// - host verifies crc, rereads on mismatch
// - main: subtract offset, scale, saturate 32 bits
// - main offset 24 bits at 07h..09h
// - offset two's complement, zero means none
// - offset shifted left to 32-bit alignment
// - chop enabled bypasses main offset
// - aux corrections 16 bits, main 24
// - corrections by commands or direct writes
// - host calibrates offset first, after settling
// - check byte ends data, never registers
// - two-bit check mode field enables it
// - aux full-scale unity at 4000h
module conv_result_device
  import conv_check_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  conv_link_if.device      link,
  input  wire logic [31:0] main_filter_out,
  input  wire logic        main_filter_valid,
  input  wire logic [23:0] aux_filter_out,
  input  wire logic        aux_filter_valid,
  input  wire logic        chop_enable
);
  typedef enum logic [1:0] {st_idle, st_send, st_cal_main, st_cal_aux} dev_state_e;

  dev_state_e  state_reg;
  logic [1:0]  check_mode_reg;
  logic [23:0] main_offset_correction_reg;
  logic [23:0] main_fullscale_correction_reg;
  logic [15:0] aux_offset_correction_reg;
  logic [15:0] aux_fullscale_correction_reg;
  logic [31:0] main_result_reg;
  logic [23:0] aux_result_reg;
  logic        main_new_reg;
  logic        aux_new_reg;
  logic [39:0] tx_buf_reg;
  logic [2:0]  tx_left_reg;
  logic        req_ready_reg;
  logic        rsp_valid_reg;
  logic [7:0]  rsp_byte_reg;
  logic        rsp_last_reg;
  logic [4:0]  cal_count_reg;
  logic signed [35:0] cal_acc_reg;

  logic        take;
  logic        main_read;
  logic        aux_read;
  logic        cal_main_done;
  logic        cal_aux_done;
  logic [7:0]  reg_rdata;

  assign take      = state_reg == st_idle && req_ready_reg && link.req_valid;
  assign main_read = take && link.req_op == op_read_main;
  assign aux_read  = take && link.req_op == op_read_aux;
  assign cal_main_done = state_reg == st_cal_main && main_filter_valid
                         && cal_count_reg == cal_samples - 5'h01;
  assign cal_aux_done  = state_reg == st_cal_aux && aux_filter_valid
                         && cal_count_reg == cal_samples - 5'h01;

  // main correction path
  logic signed [33:0] main_diff;
  logic signed [58:0] main_prod;
  logic signed [58:0] main_scaled;
  logic [31:0]        main_corrected;
  always_comb begin
    main_diff = $signed({{2{main_filter_out[31]}}, main_filter_out});
    if (!chop_enable) begin
      // zero word subtracts nothing; sign kept for negative offsets
      main_diff = main_diff - $signed({{2{main_offset_correction_reg[23]}},
                                       main_offset_correction_reg, 8'h00});
    end
    main_prod   = main_diff * $signed({1'b0, main_fullscale_correction_reg});
    main_scaled = main_prod >>> main_fs_shift;
    if (main_scaled > $signed(59'h0_7fff_ffff)) main_corrected = 32'h7fffffff;
    else if (main_scaled < -$signed(59'h0_8000_0000)) main_corrected = 32'h80000000;
    else main_corrected = main_scaled[31:0];
  end

  // aux correction path, 16-bit words aligned to the 24-bit result
  logic signed [25:0] aux_diff;
  logic signed [42:0] aux_prod;
  logic signed [42:0] aux_scaled;
  logic [23:0]        aux_corrected;
  always_comb begin
    aux_diff   = $signed({{2{aux_filter_out[23]}}, aux_filter_out})
               - $signed({{2{aux_offset_correction_reg[15]}},
                          aux_offset_correction_reg, 8'h00});
    aux_prod   = aux_diff * $signed({1'b0, aux_fullscale_correction_reg});
    aux_scaled = aux_prod >>> aux_fs_shift;
    if (aux_scaled > $signed(43'h0_7f_ffff)) aux_corrected = 24'h7fffff;
    else if (aux_scaled < -$signed(43'h0_80_0000)) aux_corrected = 24'h800000;
    else aux_corrected = aux_scaled[23:0];
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      main_result_reg <= 32'h00000000;
      aux_result_reg  <= 24'h000000;
    end else begin
      if (main_filter_valid) main_result_reg <= main_corrected;
      if (aux_filter_valid) aux_result_reg <= aux_corrected;
    end
  end

  // new-data flags; a fresh result in the read cycle keeps the flag up
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      main_new_reg <= 1'b0;
      aux_new_reg  <= 1'b0;
    end else begin
      if (main_filter_valid) main_new_reg <= 1'b1;
      else if (main_read) main_new_reg <= 1'b0;
      if (aux_filter_valid) aux_new_reg <= 1'b1;
      else if (aux_read) aux_new_reg <= 1'b0;
    end
  end

  // correction and link registers, written directly or by calibration
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      check_mode_reg                <= check_mode_reset;
      main_offset_correction_reg    <= main_ofs_reset;
      main_fullscale_correction_reg <= main_fs_unity;
      aux_offset_correction_reg     <= aux_ofs_reset;
      aux_fullscale_correction_reg  <= aux_fs_unity;
    end else if (take && link.req_op == op_reg_write) begin
      case (link.req_addr)
        addr_link_cfg:     check_mode_reg <= link.req_data[check_mode_lsb +: 2];
        addr_main_ofs_lo:  main_offset_correction_reg[7:0] <= link.req_data;
        addr_main_ofs_mid: main_offset_correction_reg[15:8] <= link.req_data;
        addr_main_ofs_hi:  main_offset_correction_reg[23:16] <= link.req_data;
        addr_main_fs_lo:   main_fullscale_correction_reg[7:0] <= link.req_data;
        addr_main_fs_mid:  main_fullscale_correction_reg[15:8] <= link.req_data;
        addr_main_fs_hi:   main_fullscale_correction_reg[23:16] <= link.req_data;
        addr_aux_ofs_lo:   aux_offset_correction_reg[7:0] <= link.req_data;
        addr_aux_ofs_hi:   aux_offset_correction_reg[15:8] <= link.req_data;
        addr_aux_fs_lo:    aux_fullscale_correction_reg[7:0] <= link.req_data;
        addr_aux_fs_hi:    aux_fullscale_correction_reg[15:8] <= link.req_data;
        default: ;
      endcase
    end else if (cal_main_done) begin
      // average of raw readings; low byte dropped by the 24-bit alignment
      main_offset_correction_reg <= 24'((cal_acc_reg + $signed(main_filter_out))
                                        >>> (cal_avg_shift + 8));
    end else if (cal_aux_done) begin
      aux_offset_correction_reg <= 16'((cal_acc_reg + $signed(aux_filter_out))
                                       >>> (cal_avg_shift + 8));
    end
  end

  always_comb begin
    case (link.req_addr)
      addr_link_cfg:     reg_rdata = {6'h00, check_mode_reg};
      addr_main_ofs_lo:  reg_rdata = main_offset_correction_reg[7:0];
      addr_main_ofs_mid: reg_rdata = main_offset_correction_reg[15:8];
      addr_main_ofs_hi:  reg_rdata = main_offset_correction_reg[23:16];
      addr_main_fs_lo:   reg_rdata = main_fullscale_correction_reg[7:0];
      addr_main_fs_mid:  reg_rdata = main_fullscale_correction_reg[15:8];
      addr_main_fs_hi:   reg_rdata = main_fullscale_correction_reg[23:16];
      addr_aux_ofs_lo:   reg_rdata = aux_offset_correction_reg[7:0];
      addr_aux_ofs_hi:   reg_rdata = aux_offset_correction_reg[15:8];
      addr_aux_fs_lo:    reg_rdata = aux_fullscale_correction_reg[7:0];
      addr_aux_fs_hi:    reg_rdata = aux_fullscale_correction_reg[15:8];
      default:           reg_rdata = 8'h00;
    endcase
  end

  // calibration averaging; the sixteenth sample is folded in at the write
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cal_count_reg <= 5'h00;
      cal_acc_reg   <= 36'sh0;
    end else if (take) begin
      cal_count_reg <= 5'h00;
      cal_acc_reg   <= 36'sh0;
    end else if (state_reg == st_cal_main && main_filter_valid) begin
      cal_count_reg <= cal_count_reg + 5'h01;
      cal_acc_reg   <= cal_acc_reg + $signed({{4{main_filter_out[31]}}, main_filter_out});
    end else if (state_reg == st_cal_aux && aux_filter_valid) begin
      cal_count_reg <= cal_count_reg + 5'h01;
      cal_acc_reg   <= cal_acc_reg + $signed({{12{aux_filter_out[23]}}, aux_filter_out});
    end
  end

  // read-back sequencer; check byte only after conversion data
  logic [7:0] main_chk;
  logic [7:0] aux_chk;
  logic       chk_on;
  always_comb begin
    chk_on   = check_mode_reg == check_sum_mode || check_mode_reg == check_crc_mode;
    main_chk = check_mode_reg == check_sum_mode ? check_sum(main_result_reg, main_bytes)
                                                : crc8(main_result_reg, main_bytes);
    aux_chk  = check_mode_reg == check_sum_mode ? check_sum({8'h00, aux_result_reg}, aux_bytes)
                                                : crc8({8'h00, aux_result_reg}, aux_bytes);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg     <= st_idle;
      req_ready_reg <= 1'b0;
      tx_buf_reg    <= 40'h0;
      tx_left_reg   <= 3'h0;
      rsp_valid_reg <= 1'b0;
      rsp_byte_reg  <= 8'h00;
      rsp_last_reg  <= 1'b0;
    end else begin
      rsp_valid_reg <= 1'b0;
      rsp_last_reg  <= 1'b0;
      case (state_reg)
        st_idle: begin
          req_ready_reg <= 1'b1;
          if (take) begin
            req_ready_reg <= 1'b0;
            case (link.req_op)
              op_read_main: begin
                state_reg   <= st_send;
                tx_buf_reg  <= {main_result_reg, main_chk};
                tx_left_reg <= chk_on ? 3'h5 : 3'h4;
              end
              op_read_aux: begin
                state_reg   <= st_send;
                tx_buf_reg  <= {aux_result_reg, aux_chk, 8'h00};
                tx_left_reg <= chk_on ? 3'h4 : 3'h3;
              end
              op_reg_read: begin
                state_reg   <= st_send;
                tx_buf_reg  <= {reg_rdata, 32'h0}; // no check byte here
                tx_left_reg <= 3'h1;
              end
              op_cal_main_ofs: state_reg <= st_cal_main;
              op_cal_aux_ofs:  state_reg <= st_cal_aux;
              default:         req_ready_reg <= 1'b1;
            endcase
          end
        end
        st_send: begin
          rsp_valid_reg <= 1'b1;
          rsp_byte_reg  <= tx_buf_reg[39:32];
          rsp_last_reg  <= tx_left_reg == 3'h1;
          tx_buf_reg    <= {tx_buf_reg[31:0], 8'h00};
          tx_left_reg   <= tx_left_reg - 3'h1;
          if (tx_left_reg == 3'h1) state_reg <= st_idle;
        end
        st_cal_main, st_cal_aux: begin
          // one zero byte marks the end of a calibration
          if (cal_main_done || cal_aux_done) begin
            rsp_valid_reg <= 1'b1;
            rsp_byte_reg  <= 8'h00;
            rsp_last_reg  <= 1'b1;
            state_reg     <= st_idle;
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  assign link.req_ready            = req_ready_reg;
  assign link.rsp_valid            = rsp_valid_reg;
  assign link.rsp_byte             = rsp_byte_reg;
  assign link.rsp_last             = rsp_last_reg;
  assign link.serial_out_ready_pin = main_new_reg;
  assign link.aux_data_ready       = aux_new_reg;
endmodule

/* File: verilog/conv_result_host.sv */
// host end: issues requests, verifies integrity byte, retries reads
`timescale 1ns/1ps
module conv_result_host
  import conv_check_pkg::*;
#(
  parameter int SETTLE_CYCLES = 1000,
  parameter int MAX_RETRIES   = 3
)(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  conv_link_if.host        link,
  input  wire logic        user_start,
  input  link_op_e         user_op,
  input  wire logic [7:0]  user_addr,
  input  wire logic [7:0]  user_data,
  input  wire logic [1:0]  user_check_mode,
  output logic             user_busy,
  output logic             user_done,
  output logic [31:0]      user_result,
  output logic             user_check_error,
  output logic             user_refused
);
  typedef enum logic [1:0] {st_idle, st_issue, st_wait} host_state_e;

  host_state_e state_reg;
  link_op_e    op_reg;
  logic [7:0]  addr_reg;
  logic [7:0]  data_reg;
  logic [39:0] rx_reg;
  logic [3:0]  retry_reg;
  logic [15:0] settle_reg;
  logic        main_ofs_done_reg;
  logic        aux_ofs_done_reg;
  logic        req_valid_reg;
  logic        busy_reg;
  logic        done_reg;
  logic [31:0] result_reg;
  logic        err_reg;
  logic        refused_reg;

  logic        settled;
  logic        fs_main_addr;
  logic        fs_aux_addr;
  logic        is_cal;
  logic        is_fs_write;
  logic        chk_on;
  logic [39:0] rx_full;
  logic [31:0] word;
  logic [7:0]  got_chk;
  logic [7:0]  want_chk;
  logic        good;

  always_comb begin
    settled      = settle_reg == 16'(SETTLE_CYCLES);
    fs_main_addr = user_addr == addr_main_fs_lo || user_addr == addr_main_fs_mid
                   || user_addr == addr_main_fs_hi;
    fs_aux_addr  = user_addr == addr_aux_fs_lo || user_addr == addr_aux_fs_hi;
    is_cal       = user_op == op_cal_main_ofs || user_op == op_cal_aux_ofs;
    // full-scale writes are refused until that converter's offset calibration is done
    is_fs_write  = user_op == op_reg_write
                   && ((fs_main_addr && !main_ofs_done_reg) || (fs_aux_addr && !aux_ofs_done_reg));
    chk_on       = user_check_mode == check_sum_mode || user_check_mode == check_crc_mode;
    rx_full      = {rx_reg[31:0], link.rsp_byte};
    if (op_reg == op_read_main) begin
      word    = chk_on ? rx_full[39:8] : rx_full[31:0];
      got_chk = rx_full[7:0];
      want_chk = user_check_mode == check_sum_mode ? check_sum(word, main_bytes)
                                                   : crc8(word, main_bytes);
    end else begin
      word    = chk_on ? {8'h00, rx_full[31:8]} : {8'h00, rx_full[23:0]};
      got_chk = rx_full[7:0];
      want_chk = user_check_mode == check_sum_mode ? check_sum(word, aux_bytes)
                                                   : crc8(word, aux_bytes);
    end
    good = !chk_on || op_reg == op_reg_read || op_reg == op_reg_write
           || op_reg == op_cal_main_ofs || op_reg == op_cal_aux_ofs || got_chk == want_chk;
  end

  // supplies and reference settle before any calibration
  always_ff @(posedge core_clk) begin
    if (!reset_n) settle_reg <= 16'h0000;
    else if (!settled) settle_reg <= settle_reg + 16'h0001;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      main_ofs_done_reg <= 1'b0;
      aux_ofs_done_reg  <= 1'b0;
    end else if (state_reg == st_wait && link.rsp_valid && link.rsp_last) begin
      if (op_reg == op_cal_main_ofs) main_ofs_done_reg <= 1'b1;
      if (op_reg == op_cal_aux_ofs) aux_ofs_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg     <= st_idle;
      op_reg        <= op_read_main;
      addr_reg      <= 8'h00;
      data_reg      <= 8'h00;
      rx_reg        <= 40'h0;
      retry_reg     <= 4'h0;
      req_valid_reg <= 1'b0;
      busy_reg      <= 1'b0;
      done_reg      <= 1'b0;
      result_reg    <= 32'h0;
      err_reg       <= 1'b0;
      refused_reg   <= 1'b0;
    end else begin
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
      case (state_reg)
        st_idle: begin
          if (user_start) begin
            if (is_fs_write || (is_cal && !settled)) begin
              refused_reg <= 1'b1;
            end else begin
              state_reg     <= st_issue;
              op_reg        <= user_op;
              addr_reg      <= user_addr;
              data_reg      <= user_data;
              retry_reg     <= 4'h0;
              req_valid_reg <= 1'b1;
              busy_reg      <= 1'b1;
              err_reg       <= 1'b0;
            end
          end
        end
        st_issue: begin
          if (link.req_ready) begin
            req_valid_reg <= 1'b0;
            rx_reg        <= 40'h0;
            if (op_reg == op_reg_write) begin
              state_reg <= st_idle; // writes carry no answer
              busy_reg  <= 1'b0;
              done_reg  <= 1'b1;
            end else begin
              state_reg <= st_wait;
            end
          end
        end
        st_wait: begin
          if (link.rsp_valid) begin
            rx_reg       <= rx_full;
            if (link.rsp_last) begin
              if (good) begin
                state_reg  <= st_idle;
                busy_reg   <= 1'b0;
                done_reg   <= 1'b1;
                result_reg <= op_reg == op_reg_read ? {24'h0, link.rsp_byte} : word;
              end else if (retry_reg == 4'(MAX_RETRIES)) begin
                state_reg <= st_idle;
                busy_reg  <= 1'b0;
                done_reg  <= 1'b1;
                err_reg   <= 1'b1;
              end else begin
                // mismatch: read the same result again
                state_reg     <= st_issue;
                req_valid_reg <= 1'b1;
                retry_reg     <= retry_reg + 4'h1;
              end
            end
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  assign link.req_valid   = req_valid_reg;
  assign link.req_op      = op_reg;
  assign link.req_addr    = addr_reg;
  assign link.req_data    = data_reg;
  assign user_busy        = busy_reg;
  assign user_done        = done_reg;
  assign user_result      = result_reg;
  assign user_check_error = err_reg;
  assign user_refused     = refused_reg;
endmodule

/* File: testbench/conv_link_sva.sv */
// link checker for the converter data path and its host
`timescale 1ns/1ps
module conv_link_sva
  import conv_check_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input link_op_e        req_op,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic       rsp_last,
  input wire logic       serial_out_ready_pin,
  input wire logic       aux_data_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic       tk, ck, rd;
  logic [1:0] mode_reg;
  logic [7:0] sum_reg;
  link_op_e   op_reg;
  assign tk = req_valid && req_ready;
  assign ck = mode_reg[0] ^ mode_reg[1];
  assign rd = op_reg == op_read_main || op_reg == op_read_aux;
  // mirror of the link-config field, seen only through taken writes
  always_ff @(posedge core_clk) begin
    if (!reset_n) mode_reg <= check_mode_reset;
    else if (tk && req_op == op_reg_write && req_addr == addr_link_cfg) mode_reg <= req_data[1:0];
  end
  always_ff @(posedge core_clk) begin
    if (tk) op_reg <= req_op;
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n || (rsp_valid && rsp_last)) sum_reg <= 8'h00;
    else if (rsp_valid) sum_reg <= sum_reg + rsp_byte;
  end
  property p_main_chk;
    tk && req_op == op_read_main && ck |->
      ##2 (rsp_valid && !rsp_last) [*4] ##1 (rsp_valid && rsp_last);
  endproperty
  a_main_chk: assert property (p_main_chk) else $error("main answer length");
  property p_aux_chk;
    tk && req_op == op_read_aux && ck |->
      ##2 (rsp_valid && !rsp_last) [*3] ##1 (rsp_valid && rsp_last);
  endproperty
  a_aux_chk: assert property (p_aux_chk) else $error("aux answer length");
  property p_main_none;
    tk && req_op == op_read_main && !ck |->
      ##2 (rsp_valid && !rsp_last) [*3] ##1 (rsp_valid && rsp_last);
  endproperty
  a_main_none: assert property (p_main_none) else $error("main extra byte");
  property p_aux_none;
    tk && req_op == op_read_aux && !ck |->
      ##2 (rsp_valid && !rsp_last) [*2] ##1 (rsp_valid && rsp_last);
  endproperty
  a_aux_none: assert property (p_aux_none) else $error("aux extra byte");
  property p_reg_one;
    tk && req_op == op_reg_read |-> ##2 rsp_valid && rsp_last;
  endproperty
  a_reg_one: assert property (p_reg_one) else $error("register answer length");
  property p_sum;
    rsp_valid && rsp_last && rd && mode_reg == check_sum_mode |-> rsp_byte == sum_reg + 8'h9b;
  endproperty
  a_sum: assert property (p_sum) else $error("checksum byte wrong");
  property p_wr_ready;
    tk && req_op == op_reg_write |=> req_ready && !rsp_valid;
  endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("write turnaround");
  property p_cal_byte;
    rsp_valid && !rd && op_reg != op_reg_read |-> rsp_last && rsp_byte == 8'h00;
  endproperty
  a_cal_byte: assert property (p_cal_byte) else $error("calibration answer");
  c_crc: cover property (tk && req_op == op_read_main && mode_reg == check_crc_mode);
  c_cal: cover property (tk && req_op == op_cal_aux_ofs);
  c_flags: cover property (serial_out_ready_pin && aux_data_ready);
endmodule

/* File: testbench/test_conversion_result_correction_and_check.sv */
// self-checking bench for both ends of the converter link
`timescale 1ns/1ps
module test_conversion_result_correction_and_check
  import conv_check_pkg::*;
;
  logic        core_clk, reset_n, user_start, chop, busy, done, cerr, mv = 0, av = 0;
  link_op_e    op, cur;
  logic [7:0]  addr, data, q[$];
  logic [1:0]  mode;
  logic [31:0] res, raw_m;
  logic [23:0] raw_a, ofs_m;
  logic [15:0] ofs_a;
  int          bad_count, samples_checked;
  conv_link_if lk();
  conv_result_device conv_result_device_inst (.core_clk, .reset_n, .link(lk),
    .main_filter_out(raw_m), .main_filter_valid(mv), .aux_filter_out(raw_a),
    .aux_filter_valid(av), .chop_enable(chop));
  conv_result_host #(.SETTLE_CYCLES(4)) conv_result_host_inst (.core_clk, .reset_n,
    .link(lk), .user_start, .user_op(op), .user_addr(addr), .user_data(data),
    .user_check_mode(mode), .user_busy(busy), .user_done(done), .user_result(res),
    .user_check_error(cerr), .user_refused());
  conv_link_sva conv_link_sva_inst (.core_clk, .reset_n, .req_valid(lk.req_valid),
    .req_ready(lk.req_ready), .req_op(lk.req_op), .req_addr(lk.req_addr),
    .req_data(lk.req_data), .rsp_valid(lk.rsp_valid), .rsp_byte(lk.rsp_byte),
    .rsp_last(lk.rsp_last), .serial_out_ready_pin(lk.serial_out_ready_pin),
    .aux_data_ready(lk.aux_data_ready));
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  // filter pulses every third cycle, so a calibration sees 16 quickly
  always @(posedge core_clk) begin
    mv <= !mv && !av;
    av <= mv;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h got %h", n, e, g);
    end
  endtask
  function automatic logic [31:0] sat(longint v, int w);
    longint m;
    m = 64'sd1 <<< (w - 1);
    v = v >= m ? m - 1 : v < -m ? -m : v;
    return 32'(v & ((m <<< 1) - 1));
  endfunction
  function automatic logic [7:0] crc_ref(logic [39:0] v, int n);
    for (int i = 8 * n + 7; i >= 8; i--) begin
      if (v[i]) v[i -: 9] ^= 9'h107;
    end
    return v[7:0];
  endfunction
  task automatic check_wire();
    int n;
    logic [39:0] v;
    logic [7:0] s;
    n = cur == op_read_main ? 4 : cur == op_read_aux ? 3 : 1;
    v = 0;
    s = 8'h9b;
    for (int i = 0; i < n; i++) begin
      v = {v[31:0], q[i]};
      s += q[i];
    end
    if (n > 1 && (mode == 1 || mode == 2)) begin
      chk("check byte", mode == 1 ? s : crc_ref({v[31:0], 8'h00}, n), q[n]);
      n++;
    end
    chk("byte count", n, q.size());
    q.delete();
  endtask
  always @(posedge core_clk) begin
    if (lk.req_valid && lk.req_ready) cur = lk.req_op;
    if (lk.rsp_valid) q.push_back(lk.rsp_byte);
    if (lk.rsp_valid && lk.rsp_last) check_wire();
  end
  task automatic xfer(link_op_e o, logic [7:0] a, logic [7:0] d);
    while (busy !== 1'b0) @(posedge core_clk);
    op <= o;
    addr <= a;
    data <= d;
    user_start <= 1;
    @(posedge core_clk);
    user_start <= 0;
    while (done !== 1'b1) @(posedge core_clk);
  endtask
  // full-scale stays unity: the bench never writes the full-scale registers
  task automatic reads();
    repeat (4) @(posedge core_clk);
    chk("ready flags", 2'h3, {lk.serial_out_ready_pin, lk.aux_data_ready});
    xfer(op_read_main, 0, 0);
    chk("main", sat($signed(raw_m) - (chop ? 0 : longint'($signed(ofs_m)) <<< 8), 32), res);
    xfer(op_read_aux, 0, 0);
    chk("aux", sat($signed(raw_a) - (longint'($signed(ofs_a)) <<< 8), 24), res);
    chk("check error", 0, cerr);
  endtask
  task automatic finish_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    {reset_n, user_start, chop, addr, data, ofs_a, ofs_m, raw_m, raw_a} = 0;
    op = op_read_main;
    mode = 2'h1;
    void'($urandom(32'h0f0cf638));
    repeat (20) @(posedge core_clk);
    reset_n <= 1;
    for (int m = 0; m < 4; m++) begin
      mode <= 2'(m);
      chop <= m == 3;
      ofs_m = 24'($urandom);
      raw_m <= $urandom;
      raw_a <= 24'($urandom);
      xfer(op_reg_write, addr_link_cfg, 8'(m));
      for (int b = 0; b < 3; b++) xfer(op_reg_write, 8'(addr_main_ofs_lo + b), ofs_m[8*b +: 8]);
      reads();
    end
    xfer(op_reg_read, addr_main_ofs_mid, 0);
    chk("reg read", {24'h0, ofs_m[15:8]}, res);
    xfer(op_reg_read, 8'h30, 0);
    chk("unmapped", 0, res);
    chop <= 0;
    xfer(op_cal_main_ofs, 0, 0);
    xfer(op_cal_aux_ofs, 0, 0);
    ofs_m = raw_m[31:8];
    ofs_a = raw_a[23:8];
    reads();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    finish_test();
  end
endmodule
